// >>> rtl/aic_ctrl.sv
// auxiliary interrupt controller: enables, read-select views, pending index and request
`timescale 1ns/1ns
module aic_ctrl (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // special function register port
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic       sfr_wr_i,
   input  wire logic       sfr_rd_i,
   input  wire logic [7:0] sfr_wdata_i,
   output logic      [7:0] sfr_rdata_o,
   // raw source levels from the peripherals
   input  wire logic [7:0] aux_src_i,
   // group enable from the extended interrupt control register
   input  wire logic       group_enable_i,
   // request and dispatch index to the core
   output logic            aux_irq_o,
   output logic      [3:0] pending_index_o
);
   // every register of the block lives in this one struct
   typedef struct packed {
      logic [7:0] enable_mask;
      logic       view_swap_select;
      logic [3:0] pending_index_field;
      logic       irq;
      logic [7:0] rdata;
   } aic_state_t;

   aic_state_t st_q;
   aic_state_t st_d;
   logic [3:0] idx_now;
   logic [7:0] pend_en;

   // address match used by both read and write paths
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
      return addr == reg_addr;
   endfunction : hit

   // sources gated by their enables; bit 2 is whichever serial source exists
   assign pend_en = aux_src_i & st_q.enable_mask;

   // fixed priority picks the lowest enabled source bit
   aic_prio_enc u_enc (
      .pend_i (pend_en),
      .idx_o  (idx_now)
   );

   // next state: register writes, read views, index and request
   always_comb begin
      st_d = st_q;
      // writes to the pending register or to unmapped addresses change nothing
      if (sfr_wr_i && hit(sfr_addr_i, aic_pkg::ENABLE_ADDR)) begin
         st_d.enable_mask = sfr_wdata_i;
      end
      // the poll register keeps only the select bit; its source bits cannot be written
      if (sfr_wr_i && hit(sfr_addr_i, aic_pkg::POLL_ADDR)) begin
         st_d.view_swap_select = sfr_wdata_i[aic_pkg::SELECT_BIT];
      end
      // read data is captured once per strobe and held until the next read
      if (sfr_rd_i) begin
         if (hit(sfr_addr_i, aic_pkg::POLL_ADDR)) begin
            st_d.rdata = st_q.view_swap_select ? aux_src_i : st_q.enable_mask;
         end else if (hit(sfr_addr_i, aic_pkg::ENABLE_ADDR)) begin
            st_d.rdata = st_q.view_swap_select ? st_q.enable_mask : aux_src_i;
         end else if (hit(sfr_addr_i, aic_pkg::PENDING_ADDR)) begin
            st_d.rdata = {aic_pkg::IDX_UPPER, st_q.pending_index_field};
         end else begin
            st_d.rdata = aic_pkg::RDATA_RST;
         end
      end
      // index and request follow the sources every cycle, one cycle behind
      st_d.pending_index_field = idx_now;
      st_d.irq = (idx_now != aic_pkg::IDX_NONE) && group_enable_i;
   end

   // state register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q.enable_mask         <= aic_pkg::ENABLE_RST;
         st_q.view_swap_select    <= aic_pkg::SELECT_RST;
         st_q.pending_index_field <= aic_pkg::INDEX_RST;
         st_q.irq                 <= aic_pkg::IRQ_RST;
         st_q.rdata               <= aic_pkg::RDATA_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from flip-flops
   assign sfr_rdata_o     = st_q.rdata;
   assign aux_irq_o       = st_q.irq;
   assign pending_index_o = st_q.pending_index_field;

   // checks on the register port, the views and the request
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_mask_write: assert property (
      sfr_wr_i && sfr_addr_i == aic_pkg::ENABLE_ADDR |=> st_q.enable_mask == $past(sfr_wdata_i))
      else $error("enable mask not stored");

   a_select_write: assert property (
      sfr_wr_i && sfr_addr_i == aic_pkg::POLL_ADDR
      |=> st_q.view_swap_select == $past(sfr_wdata_i[0]))
      else $error("read select not stored");

   a_poll_readonly: assert property (
      sfr_wr_i && sfr_addr_i == aic_pkg::POLL_ADDR |=> $stable(st_q.enable_mask))
      else $error("poll write changed enables");

   // both views, for each setting of the read select
   a_sel1_views: assert property (
      sfr_rd_i && st_q.view_swap_select && sfr_addr_i == aic_pkg::POLL_ADDR
      |=> sfr_rdata_o == $past(aux_src_i))
      else $error("poll view wrong with select one");

   a_sel1_enable: assert property (
      sfr_rd_i && st_q.view_swap_select && sfr_addr_i == aic_pkg::ENABLE_ADDR
      |=> sfr_rdata_o == $past(st_q.enable_mask))
      else $error("enable view wrong with select one");

   a_sel0_views: assert property (
      sfr_rd_i && !st_q.view_swap_select && sfr_addr_i == aic_pkg::POLL_ADDR
      |=> sfr_rdata_o == $past(st_q.enable_mask))
      else $error("poll view wrong with select zero");

   a_sel0_enable: assert property (
      sfr_rd_i && !st_q.view_swap_select && sfr_addr_i == aic_pkg::ENABLE_ADDR
      |=> sfr_rdata_o == $past(aux_src_i))
      else $error("enable view wrong with select zero");

   a_pending_upper: assert property (
      sfr_rd_i && sfr_addr_i == aic_pkg::PENDING_ADDR
      |=> sfr_rdata_o[7:4] == 4'h0 && sfr_rdata_o[3:0] == $past(pending_index_o))
      else $error("pending read wrong");

   // index codes for single sources and for the top source
   a_index_none: assert property (
      (aux_src_i & st_q.enable_mask) == 8'h00 |=> pending_index_o == aic_pkg::IDX_NONE)
      else $error("index nonzero with nothing enabled");

   a_index_top: assert property (
      aux_src_i[0] && st_q.enable_mask[0] |=> pending_index_o == aic_pkg::IDX_DIGITAL)
      else $error("highest priority source lost");

   a_index_seconds: assert property (
      (aux_src_i & st_q.enable_mask) == 8'h80 |=> pending_index_o == aic_pkg::IDX_SECONDS)
      else $error("seconds timer code wrong");

   a_index_serial_rx: assert property (
      (aux_src_i & st_q.enable_mask) == 8'h04 |=> pending_index_o == 4'h3)
      else $error("shared serial receive code wrong");

   // request follows the registered index and the group enable
   a_irq_gate: assert property (
      aux_irq_o == (pending_index_o != 4'h0 && $past(group_enable_i)))
      else $error("request not tied to index and group enable");

   a_irq_follow: assert property (
      group_enable_i && (aux_src_i & st_q.enable_mask) != 8'h00 |=> aux_irq_o)
      else $error("request missing");

   // state changes only where a write is addressed
   a_enable_hold: assert property (
      !(sfr_wr_i && sfr_addr_i == aic_pkg::ENABLE_ADDR)
      |=> $stable(st_q.enable_mask))
      else $error("enable mask changed without a write");

   a_select_hold: assert property (
      !(sfr_wr_i && sfr_addr_i == aic_pkg::POLL_ADDR)
      |=> $stable(st_q.view_swap_select))
      else $error("read select changed without a write");

   a_pending_no_write: assert property (
      sfr_wr_i && sfr_addr_i == aic_pkg::PENDING_ADDR
      |=> $stable(st_q.enable_mask) && $stable(st_q.view_swap_select))
      else $error("pending register write had an effect");

   // read data stands until the next read strobe
   a_rdata_hold: assert property (
      !sfr_rd_i |=> $stable(sfr_rdata_o))
      else $error("read data moved without a read");

   a_serial_rx_view: assert property (
      sfr_rd_i && st_q.view_swap_select && sfr_addr_i == aic_pkg::POLL_ADDR
      |=> sfr_rdata_o[aic_pkg::SRC_SER_RX] == $past(aux_src_i[aic_pkg::SRC_SER_RX]))
      else $error("shared serial bit wrong in raw view");

   // priority and range of the index
   a_index_second: assert property (
      aux_src_i[1] && st_q.enable_mask[1] && !(aux_src_i[0] && st_q.enable_mask[0])
      |=> pending_index_o == 4'h2)
      else $error("analog low voltage code wrong");

   a_seconds_lowest: assert property (
      (aux_src_i & st_q.enable_mask & 8'h7f) != 8'h00
      |=> pending_index_o != aic_pkg::IDX_SECONDS)
      else $error("seconds timer won over a higher source");

   a_index_range: assert property (
      pending_index_o <= aic_pkg::IDX_SECONDS)
      else $error("index outside the code table");

   // request drops with the group enable or with nothing pending
   a_irq_blocked: assert property (
      !group_enable_i |=> !aux_irq_o)
      else $error("request while group disabled");

   a_irq_drop: assert property (
      (aux_src_i & st_q.enable_mask) == 8'h00 |=> !aux_irq_o)
      else $error("request with nothing pending");

   // main scenarios
   c_irq_raised: cover property (aux_irq_o);
   c_two_pending: cover property ($countones(aux_src_i & st_q.enable_mask) > 1 ##1 aux_irq_o);
   c_swap_read: cover property (
      sfr_wr_i && sfr_addr_i == aic_pkg::POLL_ADDR && sfr_wdata_i[0]
      ##[1:4] sfr_rd_i && sfr_addr_i == aic_pkg::POLL_ADDR);
   c_masked_only: cover property (aux_src_i != 8'h00 && st_q.enable_mask == 8'h00);
   c_group_blocked: cover property (!group_enable_i && pending_index_o != aic_pkg::IDX_NONE);
endmodule : aic_ctrl

// >>> rtl/aic_pkg.sv
// package of constants for the auxiliary interrupt controller
package aic_pkg;
   // register addresses on the special function register port
   localparam logic [7:0] POLL_ADDR    = 8'ha4;
   localparam logic [7:0] PENDING_ADDR = 8'ha5;
   localparam logic [7:0] ENABLE_ADDR  = 8'ha6;
   // values after reset
   localparam logic [7:0] ENABLE_RST   = 8'h00;
   localparam logic       SELECT_RST   = 1'b0;
   localparam logic [3:0] INDEX_RST    = 4'h0;
   localparam logic [7:0] RDATA_RST    = 8'h00;
   localparam logic       IRQ_RST      = 1'b0;
   // field positions
   localparam int         SELECT_BIT   = 0;
   localparam int         SRC_SECONDS  = 7;
   localparam int         SRC_SUM      = 6;
   localparam int         SRC_CONV     = 5;
   localparam int         SRC_MSEC     = 4;
   localparam int         SRC_SER_TX   = 3;
   localparam int         SRC_SER_RX   = 2;
   localparam int         SRC_ANALOG   = 1;
   localparam int         SRC_DIGITAL  = 0;
   localparam int         NUM_SRC      = 8;
   // pending index codes
   localparam logic [3:0] IDX_NONE     = 4'h0;
   localparam logic [3:0] IDX_DIGITAL  = 4'h1;
   localparam logic [3:0] IDX_SECONDS  = 4'h8;
   localparam logic [3:0] IDX_UPPER    = 4'h0;
endpackage : aic_pkg

// >>> rtl/aic_prio_enc.sv
// fixed priority encoder from enabled pending sources to an index
`timescale 1ns/1ns
module aic_prio_enc (
   // enabled pending sources
   input  wire logic [7:0] pend_i,
   // index of the winning source
   output logic      [3:0] idx_o
);
   // scan lowest priority first so the lowest bit is the last to win
   always_comb begin
      idx_o = aic_pkg::IDX_NONE;
      for (int i = aic_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (pend_i[i]) begin
            idx_o = 4'(i + 1);
         end
      end
   end
endmodule : aic_prio_enc

// >>> tb/aic_src_model.sv
// peripheral source bank model driving raw source levels
`timescale 1ns/1ns
module aic_src_model (
   // clock
   input  wire logic       clk_i,
   // requested levels per source bit
   input  wire logic [7:0] level_i,
   // raw levels towards the controller
   output logic      [7:0] aux_src_o
);
   // levels move just after the falling edge, bit 2 carries serial rx or two-wire
   always_ff @(negedge clk_i) begin
      aux_src_o <= level_i;
   end
endmodule : aic_src_model

// >>> tb/tb_aux_interrupt_controller.sv
// testbench for the auxiliary interrupt controller
`timescale 1ns/1ns
module tb_aux_interrupt_controller;
   logic       clk_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic [7:0] sfr_addr_i = 8'h00;
   logic       sfr_wr_i = 1'b0;
   logic       sfr_rd_i = 1'b0;
   logic [7:0] sfr_wdata_i = 8'h00;
   logic [7:0] sfr_rdata_o;
   logic [7:0] aux_src_i;
   logic [7:0] level = 8'h00;
   logic       group_enable_i = 1'b1;
   logic       aux_irq_o;
   logic [3:0] pending_index_o;
   int         mismatches = 0;
   int         n_compared = 0;
   int         cycles = 0;
   // 125 MHz clock
   always #4 clk_i = ~clk_i;
   aic_src_model src (.clk_i(clk_i), .level_i(level), .aux_src_o(aux_src_i));
   aic_ctrl dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
      .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
      .aux_src_i(aux_src_i), .group_enable_i(group_enable_i), .aux_irq_o(aux_irq_o),
      .pending_index_o(pending_index_o));
   // verdict and end of run
   task automatic results();
      if (mismatches == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results
   // compare seen against expected
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one register write
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      @(negedge clk_i);
      sfr_wr_i = 1'b0;
   endtask : wr
   // one register read, checked the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_i);
      sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      @(negedge clk_i);
      sfr_rd_i = 1'b0;
      chk(sfr_rdata_o, exp);
   endtask : rd
   // set source levels and let them reach the outputs
   task automatic src_set(input logic [7:0] v);
      level <= v;
      repeat (3) @(negedge clk_i);
   endtask : src_set
   // hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         results();
      end
   end
   // main sequence
   initial begin
      repeat (2) @(negedge clk_i);
      rst_n_i = 1'b1;
      rd(8'ha4, 8'h00);
      rd(8'ha5, 8'h00);
      rd(8'ha6, 8'h00);
      wr(8'ha6, 8'h5a);
      src_set(8'h3c);
      rd(8'ha4, 8'h5a);
      rd(8'ha6, 8'h3c);
      rd(8'ha5, 8'h04);
      chk({7'h00, aux_irq_o}, 8'h01);
      group_enable_i = 1'b0;
      repeat (2) @(negedge clk_i);
      chk({7'h00, aux_irq_o}, 8'h00);
      chk({4'h0, pending_index_o}, 8'h04);
      group_enable_i = 1'b1;
      wr(8'ha4, 8'hff);
      wr(8'ha5, 8'hff);
      rd(8'ha4, 8'h3c);
      rd(8'ha6, 8'h5a);
      wr(8'ha4, 8'hfe);
      rd(8'ha4, 8'h5a);
      rd(8'ha7, 8'h00);
      wr(8'ha6, 8'hff);
      // sweep each source as the highest pending one
      for (int i = 0; i < 8; i++) begin
         src_set(8'hff << i);
         chk({4'h0, pending_index_o}, 8'(i + 1));
         rd(8'ha5, 8'(i + 1));
      end
      src_set(8'h04);
      chk({4'h0, pending_index_o}, 8'h03);
      rd(8'ha6, 8'h04);
      src_set(8'h00);
      chk({7'h00, aux_irq_o}, 8'h00);
      chk({4'h0, pending_index_o}, 8'h00);
      wr(8'ha6, 8'h00);
      src_set(8'hff);
      rd(8'ha5, 8'h00);
      chk({7'h00, aux_irq_o}, 8'h00);
      // reset in mid-run clears enables, select, index and request
      wr(8'ha6, 8'h81);
      wr(8'ha4, 8'h01);
      chk({4'h0, pending_index_o}, 8'h01);
      rst_n_i = 1'b0;
      @(negedge clk_i);
      rst_n_i = 1'b1;
      chk({7'h00, aux_irq_o}, 8'h00);
      chk({4'h0, pending_index_o}, 8'h00);
      rd(8'ha4, 8'h00);
      rd(8'ha6, 8'hff);
      results();
   end
endmodule : tb_aux_interrupt_controller
